// ### fmg_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the flash mode guard. Included by every design file of the block.
`ifndef FMG_REGS_VH
`define FMG_REGS_VH

// ---------------------------------------------------------------------
// Register offsets (8-bit register port)
// ---------------------------------------------------------------------
`define FMG_ADDR_KEY        8'h00
`define FMG_ADDR_MODE       8'h01
`define FMG_ADDR_STATUS     8'h02
`define FMG_ADDR_SEQCLR     8'h03
`define FMG_ADDR_DACTL      8'h04
`define FMG_ADDR_AREA       8'h05
`define FMG_ADDR_WDL_LO     8'h06
`define FMG_ADDR_WDL_HI     8'h07
`define FMG_ADDR_WDH_LO     8'h08
`define FMG_ADDR_WDH_HI     8'h09
`define FMG_ADDR_EXCTL      8'h0A
`define FMG_ADDR_SWS_LO     8'h0B
`define FMG_ADDR_SWS_HI     8'h0C
`define FMG_ADDR_SWE_LO     8'h0D
`define FMG_ADDR_SWE_HI     8'h0E

// ---------------------------------------------------------------------
// Key, mode encodings and reset values
// ---------------------------------------------------------------------
`define FMG_KEY_VALUE       8'hA5
`define FMG_MODE_READ       8'h08
`define FMG_MODE_DATA       8'h10
`define FMG_MODE_CODE_S1    8'h12
`define FMG_MODE_CODE_S2    8'h92
`define FMG_MODE_CODE       8'h82
`define FMG_MODE_RESET      8'h08
`define FMG_STATUS_RESET    8'h00

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define FMG_ERR_BIT         0
`define FMG_SEQCLR_BIT      0
`define FMG_DAEN_BIT        0
`define FMG_EXA_BIT         0
`define FMG_EXSTART_BIT     7
`define FMG_EXOP_MSB        2
`define FMG_EXOP_LSB        0
`define FMG_OP_SHIELD       3'h2
`define FMG_BLK_W           10

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define FMG_EXSEQ_CYCLES    8

`endif

// ### fmg_unlock.v
// Protected unlock sequence checker for the mode register.
// Assumes one write strobe per cycle on the same clock as the caller.
`default_nettype none

module fmg_unlock (
    input  wire       mclk,
    input  wire       rst,
    input  wire       wr,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       allowed,
    input  wire [7:0] cur_mode,
    output reg        mode_we,
    output reg  [7:0] mode_val,
    output reg        err_set,
    output reg        err_clr
);

`include "fmg_regs.vh"

// ---------------------------------------------------------------------
// States, one-hot
// ---------------------------------------------------------------------
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_KEY  = 4'h2;
localparam [3:0] ST_M1   = 4'h4;
localparam [3:0] ST_M2   = 4'h8;

reg  [3:0] state;     // Sequence position
reg  [7:0] first_val; // Mode value of the first mode write
reg        legal;     // Requested transition allowed from cur_mode

// Legal mode transitions; staged code entry and exit only
always @* begin
    legal = 1'b0;
    case (cur_mode)
        `FMG_MODE_READ:    legal = (first_val == `FMG_MODE_CODE_S1) ||
                                   (first_val == `FMG_MODE_DATA);
        `FMG_MODE_CODE_S1: legal = (first_val == `FMG_MODE_CODE_S2) ||
                                   (first_val == `FMG_MODE_READ);
        `FMG_MODE_CODE_S2: legal = (first_val == `FMG_MODE_CODE) ||
                                   (first_val == `FMG_MODE_CODE_S1);
        `FMG_MODE_CODE:    legal = (first_val == `FMG_MODE_CODE_S2);
        `FMG_MODE_DATA:    legal = (first_val == `FMG_MODE_READ);
        default:           legal = 1'b0;
    endcase
end

// ---------------------------------------------------------------------
// Sequence tracker
// ---------------------------------------------------------------------
// mode_we, err_set and err_clr are one-cycle pulses registered one edge after the write; mode_val holds
always @(posedge mclk) begin
    if (rst) begin
        state     <= ST_IDLE;
        first_val <= 8'h00;
        mode_we   <= 1'b0;
        mode_val  <= `FMG_MODE_RESET;
        err_set   <= 1'b0;
        err_clr   <= 1'b0;
    end else begin
        mode_we <= 1'b0;
        err_set <= 1'b0;
        err_clr <= 1'b0;
        if (wr && addr == `FMG_ADDR_KEY && wdata == `FMG_KEY_VALUE &&
            allowed) begin
            // Key restarts the sequence and clears the old error
            state   <= ST_KEY;
            err_clr <= 1'b1;
        end else if (wr && state != ST_IDLE) begin
            case (state)
                ST_KEY: begin
                    if (addr == `FMG_ADDR_MODE) begin
                        first_val <= wdata;
                        state     <= ST_M1;
                    end else begin
                        state   <= ST_IDLE;
                        err_set <= 1'b1;
                    end
                end
                ST_M1: begin
                    if (addr == `FMG_ADDR_MODE && wdata == ~first_val) begin
                        state <= ST_M2;
                    end else begin
                        state   <= ST_IDLE;
                        err_set <= 1'b1;
                    end
                end
                ST_M2: begin
                    state <= ST_IDLE;
                    if (addr == `FMG_ADDR_MODE && wdata == first_val &&
                        legal) begin
                        mode_we  <= 1'b1;
                        mode_val <= first_val;
                    end else begin
                        err_set <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
end

endmodule // fmg_unlock

`default_nettype wire

// ### fmg_top.v
// Flash mode guard: mode register behind a protected unlock sequence,
// protection status, sequencer register clear and shield window setup.
// Assumes a single-clock register port and a busy level from the main
// code/data sequencer on the same clock.
//
// Summary of operation
// - Three modes: code, data programming, read
// - Mode changes need key then value, inverse, value
// - Interfering write blocks update, sets error flag
// - Error flag cleared by reset or new key
// - Unlock works only when cleared and stopped
// - Key register write-only, reads as zero
// - Mode register resets to read mode
// - Data mode entered only from read mode, code mode only through its two staged steps
// - Writing start with code two launches window
// - Block number uses low ten bits
// - Data mode encoded one-zero, read zero-eight
`default_nettype none

`include "fmg_regs.vh"

module fmg_top #(
    parameter EXSEQ_CYCLES = `FMG_EXSEQ_CYCLES // Extra sequencer run time
) (
    input  wire       mclk,
    input  wire       rst,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    input  wire       main_seq_busy,
    output reg  [7:0] rdata,
    output reg        mode_read,
    output reg        mode_code,
    output reg        mode_data,
    output reg        prot_err,
    output reg        extra_busy,
    output reg  [9:0] shield_start,
    output reg  [9:0] shield_end
);

// ---------------------------------------------------------------------
// Register state
// ---------------------------------------------------------------------
reg  [7:0] mode;        // Programming mode control
reg        seq_clr;     // Sequencer register clear bit
reg        da_en;       // Data area access enable
reg        extra_area_select_bit;         // Extra area select bit
reg  [15:0] wd_low;     // Write data low (window start)
reg  [15:0] wd_high;    // Write data high (window end plus one)
reg        ex_start;    // Extra sequencer start bit
reg  [2:0] ex_op;       // Extra sequencer operation code
reg  [7:0] ex_cnt;      // Extra sequencer run counter
reg  [9:0] sw_start;    // Shield window start block
reg  [9:0] sw_end;      // Shield window end block plus one
reg        err_flag;    // Protection error flag

wire       stopped;     // Both sequencers idle
wire       allowed;     // Unlock sequence may act
wire       mode_we;
wire [7:0] mode_val;
wire       err_set;
wire       err_clr;

assign stopped = !main_seq_busy && !ex_start;
assign allowed = !seq_clr && stopped;

// ---------------------------------------------------------------------
// Unlock sequence checker
// ---------------------------------------------------------------------
fmg_unlock u_unlock (
    .mclk     (mclk),
    .rst      (rst),
    .wr       (wr),
    .addr     (addr),
    .wdata    (wdata),
    .allowed  (allowed),
    .cur_mode (mode),
    .mode_we  (mode_we),
    .mode_val (mode_val),
    .err_set  (err_set),
    .err_clr  (err_clr)
);

// ---------------------------------------------------------------------
// Mode register and error flag
// ---------------------------------------------------------------------
// Only the checker may change the mode; direct writes are just tracked
always @(posedge mclk) begin
    if (rst) begin
        mode     <= `FMG_MODE_RESET;
        err_flag <= 1'b0;
    end else begin
        if (mode_we) begin
            mode <= mode_val;
        end
        // Set wins over clear so no error is lost
        if (err_set) begin
            err_flag <= 1'b1;
        end else if (err_clr) begin
            err_flag <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------------
// Sequencer-side registers
// ---------------------------------------------------------------------
// Clear bit only moves while both sequencers are stopped
always @(posedge mclk) begin
    if (rst) begin
        seq_clr  <= 1'b0;
        da_en    <= 1'b0;
        extra_area_select_bit      <= 1'b0;
        wd_low   <= 16'h0000;
        wd_high  <= 16'h0000;
        ex_start <= 1'b0;
        ex_op    <= 3'h0;
        ex_cnt   <= 8'h00;
        sw_start <= 10'h000;
        sw_end   <= 10'h000;
    end else begin
        // Data area enable is software-owned
        if (wr && addr == `FMG_ADDR_DACTL) begin
            da_en <= wdata[`FMG_DAEN_BIT];
        end
        if (wr && addr == `FMG_ADDR_SEQCLR && stopped) begin
            seq_clr <= wdata[`FMG_SEQCLR_BIT];
        end
        if (seq_clr) begin
            // Holding clear wipes the area bit, write data and extra sequencer control; the shield window keeps its value
            extra_area_select_bit      <= 1'b0;
            wd_low   <= 16'h0000;
            wd_high  <= 16'h0000;
            ex_start <= 1'b0;
            ex_op    <= 3'h0;
            ex_cnt   <= 8'h00;
        end else if (ex_start) begin
            // Running: count down, then apply the operation
            if (ex_cnt == 8'h00) begin
                ex_start <= 1'b0;
                if (ex_op == `FMG_OP_SHIELD) begin
                    sw_start <= wd_low[`FMG_BLK_W-1:0];
                    sw_end   <= wd_high[`FMG_BLK_W-1:0];
                end
            end else begin
                ex_cnt <= ex_cnt - 8'h01;
            end
        end else if (wr) begin
            // Writes accepted only while idle and not clearing
            if (addr == `FMG_ADDR_AREA) begin
                extra_area_select_bit <= wdata[`FMG_EXA_BIT];
            end else if (addr == `FMG_ADDR_WDL_LO) begin
                wd_low[7:0] <= wdata;
            end else if (addr == `FMG_ADDR_WDL_HI) begin
                wd_low[15:8] <= wdata;
            end else if (addr == `FMG_ADDR_WDH_LO) begin
                wd_high[7:0] <= wdata;
            end else if (addr == `FMG_ADDR_WDH_HI) begin
                wd_high[15:8] <= wdata;
            end else if (addr == `FMG_ADDR_EXCTL) begin
                ex_start <= wdata[`FMG_EXSTART_BIT];
                ex_op    <= wdata[`FMG_EXOP_MSB:`FMG_EXOP_LSB];
                ex_cnt   <= EXSEQ_CYCLES[7:0] - 8'h01;
            end
        end
    end
end

// ---------------------------------------------------------------------
// Read port
// ---------------------------------------------------------------------
// Data stand one cycle after the read strobe, zero otherwise
always @(posedge mclk) begin
    if (rst) begin
        rdata <= 8'h00;
    end else if (rd) begin
        if (addr == `FMG_ADDR_KEY) begin
            rdata <= 8'h00;
        end else if (addr == `FMG_ADDR_MODE) begin
            rdata <= mode;
        end else if (addr == `FMG_ADDR_STATUS) begin
            rdata <= {7'h00, err_flag};
        end else if (addr == `FMG_ADDR_SEQCLR) begin
            rdata <= {7'h00, seq_clr};
        end else if (addr == `FMG_ADDR_DACTL) begin
            rdata <= {7'h00, da_en};
        end else if (addr == `FMG_ADDR_AREA) begin
            rdata <= {7'h00, extra_area_select_bit};
        end else if (addr == `FMG_ADDR_WDL_LO) begin
            rdata <= wd_low[7:0];
        end else if (addr == `FMG_ADDR_WDL_HI) begin
            rdata <= wd_low[15:8];
        end else if (addr == `FMG_ADDR_WDH_LO) begin
            rdata <= wd_high[7:0];
        end else if (addr == `FMG_ADDR_WDH_HI) begin
            rdata <= wd_high[15:8];
        end else if (addr == `FMG_ADDR_EXCTL) begin
            rdata <= {ex_start, 4'h0, ex_op};
        end else if (addr == `FMG_ADDR_SWS_LO) begin
            rdata <= sw_start[7:0];
        end else if (addr == `FMG_ADDR_SWS_HI) begin
            rdata <= {6'h00, sw_start[9:8]};
        end else if (addr == `FMG_ADDR_SWE_LO) begin
            rdata <= sw_end[7:0];
        end else if (addr == `FMG_ADDR_SWE_HI) begin
            rdata <= {6'h00, sw_end[9:8]};
        end else begin
            rdata <= 8'h00;  // Unmapped reads as zero
        end
    end else begin
        rdata <= 8'h00;
    end
end

// ---------------------------------------------------------------------
// Registered status outputs
// ---------------------------------------------------------------------
// One cycle behind the registers so every output is a flip-flop
always @(posedge mclk) begin
    if (rst) begin
        mode_read    <= 1'b1;
        mode_code    <= 1'b0;
        mode_data    <= 1'b0;
        prot_err     <= 1'b0;
        extra_busy   <= 1'b0;
        shield_start <= 10'h000;
        shield_end   <= 10'h000;
    end else begin
        mode_read    <= (mode == `FMG_MODE_READ);
        mode_code    <= (mode == `FMG_MODE_CODE);
        mode_data    <= (mode == `FMG_MODE_DATA);
        prot_err     <= err_flag;
        extra_busy   <= ex_start;
        shield_start <= sw_start;
        shield_end   <= sw_end;
    end
end

endmodule // fmg_top

`default_nettype wire

// ### fmg_top_checker.sv
// Concurrent checks on the ports of the flash mode guard top level.
// Assumes clear bit writes are made only while both sequencers are idle.
`default_nettype none

module fmg_top_checker #(
    parameter int EXSEQ_CYCLES = 8 // Extra sequencer run time
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       main_seq_busy,
    input wire logic [7:0] rdata,
    input wire logic       mode_read,
    input wire logic       mode_code,
    input wire logic       mode_data,
    input wire logic       prot_err,
    input wire logic       extra_busy,
    input wire logic [9:0] shield_start,
    input wire logic [9:0] shield_end
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [8:0] busy_cnt; // Cycles the extra sequencer has run
    logic       key_ok;   // Key write that may open a sequence
    logic       clr_seen; // Sequencer clear bit as last written

    assign key_ok = wr && addr == 8'h00 && wdata == 8'hA5
                    && !main_seq_busy && !extra_busy && !clr_seen;

    // Mirror of the clear bit; a set bit keeps the key from acting
    always_ff @(posedge mclk) begin
        if (rst) begin
            clr_seen <= 1'b0;
        end else if (wr && addr == 8'h03 && !main_seq_busy
                     && !extra_busy) begin
            clr_seen <= wdata[0];
        end
    end

    // Run length counter; a repetition cannot take the parameter
    always_ff @(posedge mclk) begin
        if (rst || !extra_busy) begin
            busy_cnt <= 9'h000;
        end else begin
            busy_cnt <= busy_cnt + 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_reset_state;
        $fell(rst) |-> mode_read && !mode_code && !prot_err;
    endproperty
    property p_modes;
        $onehot0({mode_read, mode_code, mode_data});
    endproperty
    property p_key_read;
        rd && addr == 8'h00 |=> rdata == 8'h00;
    endproperty
    property p_status_read;
        rd && addr == 8'h02 |=> rdata == {7'h00, prot_err};
    endproperty
    // Data mode only after a full sequence taken from read mode
    property p_data_entry;
        $rose(mode_data) |-> $past(mode_read)
            && $past(wr && addr == 8'h01 && wdata == 8'h10, 3)
            && !$past(main_seq_busy, 6);
    endproperty
    property p_code_entry;
        $rose(mode_code) |-> $past(wr && addr == 8'h01 && wdata == 8'h82, 3);
    endproperty
    property p_err_set;
        key_ok ##1 (wr && addr != 8'h00 && addr != 8'h01) |-> ##[1:3] prot_err;
    endproperty
    property p_err_clr;
        key_ok |-> ##3 !prot_err;
    endproperty
    property p_ex_start;
        $rose(extra_busy) |-> $past(wr && addr == 8'h0A && wdata[7], 2);
    endproperty
    property p_ex_len;
        $fell(extra_busy) |-> busy_cnt == EXSEQ_CYCLES;
    endproperty
    // Window outputs move only as the extra sequencer finishes
    property p_window;
        $changed(shield_start) || $changed(shield_end) |-> $fell(extra_busy);
    endproperty

    a_reset_state: assert property (p_reset_state)
        else $error("mode or error flag wrong after reset");
    a_modes: assert property (p_modes)
        else $error("more than one mode output high");
    a_key_read: assert property (p_key_read)
        else $error("key register read not zero");
    a_status_read: assert property (p_status_read)
        else $error("status read differs from error flag");
    a_data_entry: assert property (p_data_entry)
        else $error("data mode entered without valid sequence");
    a_code_entry: assert property (p_code_entry)
        else $error("code mode entered without final mode write");
    a_err_set: assert property (p_err_set)
        else $error("interfering write did not raise error flag");
    a_err_clr: assert property (p_err_clr)
        else $error("key write did not clear error flag");
    a_ex_start: assert property (p_ex_start)
        else $error("extra sequencer started without start write");
    a_ex_len: assert property (p_ex_len)
        else $error("extra sequencer run length wrong");
    a_window: assert property (p_window)
        else $error("window changed outside sequencer end");

    c_data: cover property ($rose(mode_data));
    c_code: cover property ($rose(mode_code));
    c_err: cover property ($rose(prot_err));
    c_window: cover property ($fell(extra_busy));
endmodule // fmg_top_checker

bind fmg_top fmg_top_checker #(.EXSEQ_CYCLES(EXSEQ_CYCLES)) u_chk (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .main_seq_busy(main_seq_busy), .rdata(rdata),
    .mode_read(mode_read), .mode_code(mode_code), .mode_data(mode_data),
    .prot_err(prot_err), .extra_busy(extra_busy),
    .shield_start(shield_start), .shield_end(shield_end)
);

`default_nettype wire

// ### tb.sv
// Self-checking bench for the flash mode guard top level.
// Assumes the design files and the checker are compiled before it.
`default_nettype none

`include "fmg_regs.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int EXC = 4; // Shortened extra sequencer run
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       main_seq_busy = 1'b0;
    logic [7:0] rdata;
    logic       mode_read, mode_code, mode_data, prot_err, extra_busy;
    logic [9:0] shield_start;
    logic [9:0] shield_end;
    int         err_total = 0;
    int         tests_run = 0;
    int         cyc = 0;

    always #25 mclk = ~mclk;

    fmg_top #(.EXSEQ_CYCLES(EXC)) u_dut (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .main_seq_busy(main_seq_busy), .rdata(rdata),
        .mode_read(mode_read), .mode_code(mode_code),
        .mode_data(mode_data), .prot_err(prot_err),
        .extra_busy(extra_busy), .shield_start(shield_start),
        .shield_end(shield_end)
    );

    // ------------------------------------------------------------------
    // Shared tasks; each drive task starts on a rising edge
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        tests_run++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge mclk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk($sformatf("reg %h", a), e, rdata);
    endtask

    // Key, value, inverse, value; then read back the mode register
    task automatic seq(input logic [7:0] v, input logic [7:0] e);
        wr_reg(8'h00, `FMG_KEY_VALUE);
        wr_reg(8'h01, v);
        wr_reg(8'h01, ~v);
        wr_reg(8'h01, v);
        idle(1);
        rd_chk(8'h01, e);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        @(negedge mclk);
        chk("modes", 3'b100, {mode_read, mode_code, mode_data});
        rd_chk(8'h01, 8'h08);
        wr_reg(8'h02, 8'hFF);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'hFF, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_err;
        wr_reg(8'h00, 8'hA5);
        wr_reg(8'h04, 8'h01);
        idle(1);
        rd_chk(8'h02, 8'h01);
        chk("err", 1'b1, prot_err);
        rd_chk(8'h01, 8'h08);
        wr_reg(8'h00, 8'hA5);
        idle(2);
        rd_chk(8'h02, 8'h00);
        wr_reg(8'h00, 8'hA5);
        wr_reg(8'h01, 8'h10);
        wr_reg(8'h01, 8'h10);
        wr_reg(8'h01, 8'h10);
        idle(1);
        rd_chk(8'h01, 8'h08);
        rd_chk(8'h02, 8'h01);
        $display("test error done");
    endtask

    task automatic t_data;
        seq(8'h10, 8'h10);
        chk("modes", 3'b001, {mode_read, mode_code, mode_data});
        rd_chk(8'h02, 8'h00);
        seq(8'h12, 8'h10);
        rd_chk(8'h02, 8'h01);
        @(posedge mclk) main_seq_busy <= 1'b1;
        seq(8'h08, 8'h10);
        @(posedge mclk) main_seq_busy <= 1'b0;
        wr_reg(8'h03, 8'h01);
        seq(8'h08, 8'h10);
        rd_chk(8'h02, 8'h01);
        wr_reg(8'h03, 8'h00);
        seq(8'h08, 8'h08);
        $display("test data done");
    endtask

    task automatic t_code;
        seq(8'h12, 8'h12);
        seq(8'h92, 8'h92);
        seq(8'h82, 8'h82);
        chk("modes", 3'b010, {mode_read, mode_code, mode_data});
        wr_reg(8'h05, 8'h01);
        wr_reg(8'h06, 8'h0C);
        wr_reg(8'h07, 8'hFC);
        wr_reg(8'h08, 8'hFF);
        wr_reg(8'h09, 8'h03);
        wr_reg(8'h0A, 8'h82);
        idle(2);
        @(negedge mclk);
        chk("busy", 1'b1, extra_busy);
        idle(EXC + 1);
        @(negedge mclk);
        chk("busy", 1'b0, extra_busy);
        chk("start", 10'h00C, shield_start);
        chk("end", 10'h3FF, shield_end);
        rd_chk(8'h0B, 8'h0C);
        rd_chk(8'h0C, 8'h00);
        rd_chk(8'h0D, 8'hFF);
        rd_chk(8'h0E, 8'h03);
        wr_reg(8'h06, 8'h05);
        wr_reg(8'h0A, 8'h81);
        idle(EXC + 3);
        @(negedge mclk);
        chk("start", 10'h00C, shield_start);
        seq(8'h92, 8'h92);
        seq(8'h12, 8'h12);
        seq(8'h08, 8'h08);
        chk("modes", 3'b100, {mode_read, mode_code, mode_data});
        $display("test code done");
    endtask

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic results;
        $display("tests_run %0d err_total %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Run needs under two hundred cycles; far past that means a hang
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            $display("FAIL watchdog expected done seen running");
            err_total++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_err();
        t_data();
        t_code();
        results();
    end
endmodule // tb

`default_nettype wire
